// ===== hw/die_guard_consts.vh
// constants for the die sensor window checker
`ifndef DIE_GUARD_CONSTS_VH
`define DIE_GUARD_CONSTS_VH
// register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CLEAR 8'h08
`define REG_IRQ_EN 8'h0C
`define REG_CRIT 8'h10
`define REG_LIVE 8'h14
`define REG_CFG_BASE 8'h20
// sensor types
`define TYPE_RED 3'h0
`define TYPE_YELLOW 3'h1
`define TYPE_GREEN 3'h2
`define TYPE_QUICK 3'h3
`define TYPE_CONST 3'h4
`define TYPE_SPECIAL 3'h5
// stop kinds
`define STOP_TOP 2'h0
`define STOP_EMERG 2'h1
`define STOP_SMART 2'h2
// config word A field positions
`define CFGA_TYPE_LSB 0
`define CFGA_STOP_LSB 4
`define CFGA_COUNT_LSB 8
// config word B field positions
`define CFGB_START_LSB 0
`define CFGB_END_LSB 16
// reset values
`define CFGA_RESET 32'h0000_0007
`define CFGB_RESET 32'h0000_0000
`define CRIT_RESET 32'h0000_00B4
`endif

// ===== hw/die_sensor_window_checker.v
// die sensor window checker top: pin sync, stroke marks, registers, stop commands
// Function
// - normally open actuates on closing to ground
// - normally closed actuates when circuit opens
// - green sensors have start/end angle window
// - no actuation within window stops press
// - per-sensor stop kind: top, emergency, smart
// - red and yellow ignore window and angle
// - type selectable per sensor, any mixture
// - yellow closing at any angle stops
// - red opening at any angle stops
// - green: on in window, off before next
// - green stuck on or never on stops
// - quick check: pulse inside window only
// - constant: on across whole window; code flags a drop inside it, not a rise after it opens
// - special: actuate within configured stroke count
// - special: exceeding stroke limit stops press
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "die_guard_consts.vh"
module die_sensor_window_checker #(
  parameter NS = 4,
  parameter AW = 10
) (
  input wire core_clk,
  input wire rstn,
  input wire [NS-1:0] sensor_closed,
  input wire [AW-1:0] crank_angle,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output wire stop_top,
  output wire stop_emerg,
  output wire stroke_mark,
  output wire irq
);
  reg [NS-1:0] sync1_ff;
  reg [NS-1:0] sync2_ff;
  reg [AW-1:0] angle_ff;
  reg stroke_ff;
  reg run_ff;
  reg [AW-1:0] crit_ff;
  reg [NS-1:0] status_ff;
  reg [NS-1:0] emerg_ff;
  reg [NS-1:0] irq_en_ff;
  reg [31:0] nxt_rdata;
  wire [NS-1:0] fault;
  wire [NS-1:0] clr;
  wire [NS-1:0] emerg_now;
  wire [32*NS-1:0] cfga_all;
  wire [32*NS-1:0] cfgb_all;
  wire [2*NS-1:0] kind_all;
  wire cfg_hit;
  wire [7:0] cfg_off;
  integer k;
  integer j;
  // full-width reset value, cut to the angle width on purpose
  localparam [31:0] CRIT_INIT = `CRIT_RESET;

  // which sensor a config address names
  function [7:0] cfg_index;
    input [7:0] a;
    begin
      cfg_index = (a - `REG_CFG_BASE) >> 3;
    end
  endfunction

  assign cfg_off = addr - `REG_CFG_BASE;
  assign cfg_hit = (addr >= `REG_CFG_BASE) && (cfg_index(addr) < NS) && (addr[1:0] == 2'b00);

  // contact pins are asynchronous to the core clock
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1_ff <= {NS{1'b0}};
      sync2_ff <= {NS{1'b0}};
    end
    else
    begin
      sync1_ff <= sensor_closed;
      sync2_ff <= sync1_ff;
    end
  end

  // the angle source runs on this clock; a backward step is a new stroke
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      angle_ff <= {AW{1'b0}};
      stroke_ff <= 1'b0;
    end
    else
    begin
      angle_ff <= crank_angle;
      stroke_ff <= crank_angle < angle_ff;
    end
  end
  assign stroke_mark = stroke_ff;

  // one checker per sensor input
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1)
    begin : chk
      sensor_window_check #(
        .AW(AW)
      ) u_chk (
        .core_clk(core_clk),
        .rstn(rstn),
        .run(run_ff),
        .closed(sync2_ff[g]),
        .angle(angle_ff),
        .stroke(stroke_ff),
        .wr_a(wr && cfg_hit && (cfg_index(addr) == g) && !cfg_off[2]),
        .wr_b(wr && cfg_hit && (cfg_index(addr) == g) && cfg_off[2]),
        .wdata(wdata),
        .cfg_a(cfga_all[32*g+:32]),
        .cfg_b(cfgb_all[32*g+:32]),
        .stop_kind(kind_all[2*g+:2]),
        .fault(fault[g])
      );
      // smart stop: before the critical angle brake hard, past it finish the stroke
      assign emerg_now[g] = (kind_all[2*g+:2] == `STOP_EMERG) ||
                            ((kind_all[2*g+:2] == `STOP_SMART) && (angle_ff < crit_ff));
    end
  endgenerate

  assign clr = (wr && addr == `REG_CLEAR) ? wdata[NS-1:0] : {NS{1'b0}};

  // control registers
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      run_ff <= 1'b0;
      crit_ff <= CRIT_INIT[AW-1:0];
      irq_en_ff <= {NS{1'b0}};
    end
    else if (wr)
    begin
      if (addr == `REG_CTRL)
        run_ff <= wdata[0];
      if (addr == `REG_CRIT)
        crit_ff <= wdata[AW-1:0];
      if (addr == `REG_IRQ_EN)
        irq_en_ff <= wdata[NS-1:0];
    end
  end

  // sticky faults; a new fault beats a clear in the same cycle
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      status_ff <= {NS{1'b0}};
      emerg_ff <= {NS{1'b0}};
    end
    else
    begin
      for (k = 0; k < NS; k = k + 1)
      begin
        if (fault[k] && !status_ff[k])
        begin
          status_ff[k] <= 1'b1;
          emerg_ff[k] <= emerg_now[k];
        end
        else if (fault[k])
        begin
          // a fault in the clear cycle keeps the bit set
          if (emerg_now[k])
            emerg_ff[k] <= 1'b1;
        end
        else if (clr[k])
          status_ff[k] <= 1'b0;
      end
    end
  end

  // stop commands hold until software clears the fault
  assign stop_emerg = |(status_ff & emerg_ff);
  assign stop_top = |(status_ff & ~emerg_ff);
  assign irq = |(status_ff & irq_en_ff);

  // read mux; unmapped and write-only addresses read zero
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    j = 0;
    if (addr == `REG_CTRL)
      nxt_rdata[0] = run_ff;
    else if (addr == `REG_STATUS)
      nxt_rdata[NS-1:0] = status_ff;
    else if (addr == `REG_IRQ_EN)
      nxt_rdata[NS-1:0] = irq_en_ff;
    else if (addr == `REG_CRIT)
      nxt_rdata[AW-1:0] = crit_ff;
    else if (addr == `REG_LIVE)
    begin
      nxt_rdata[NS-1:0] = sync2_ff;
      nxt_rdata[16+:AW] = angle_ff;
    end
    else if (cfg_hit)
    begin
      for (j = 0; j < NS; j = j + 1)
      begin
        if (cfg_index(addr) == j)
          nxt_rdata = cfg_off[2] ? cfgb_all[32*j+:32] : cfga_all[32*j+:32];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= nxt_rdata;
    else
      rdata <= 32'h0000_0000;
  end
endmodule

// ===== hw/sensor_window_check.v
// per-sensor polarity, window and stroke-count evaluation with its own config words
`timescale 1ns/1ns
`include "die_guard_consts.vh"
module sensor_window_check #(
  parameter AW = 10
) (
  input wire core_clk,
  input wire rstn,
  input wire run,
  input wire closed,
  input wire [AW-1:0] angle,
  input wire stroke,
  input wire wr_a,
  input wire wr_b,
  input wire [31:0] wdata,
  output wire [31:0] cfg_a,
  output wire [31:0] cfg_b,
  output wire [1:0] stop_kind,
  output reg fault
);
  reg [31:0] cfga_ff;
  reg [31:0] cfgb_ff;
  reg act_ff;
  reg inwin_ff;
  reg seen_ff;
  reg off_ff;
  reg [7:0] cnt_ff;
  wire [2:0] typ;
  wire [7:0] limit;
  wire [AW-1:0] w_start;
  wire [AW-1:0] w_end;
  wire act;
  wire inwin;
  wire w_open;
  wire w_close;

  // window may straddle the top of stroke, so wrap is allowed
  function in_window;
    input [AW-1:0] a;
    input [AW-1:0] s;
    input [AW-1:0] e;
    begin
      if (s <= e)
        in_window = (a >= s) && (a <= e);
      else
        in_window = (a >= s) || (a <= e);
    end
  endfunction

  assign typ = cfga_ff[`CFGA_TYPE_LSB+:3];
  assign stop_kind = cfga_ff[`CFGA_STOP_LSB+:2];
  assign limit = cfga_ff[`CFGA_COUNT_LSB+:8];
  assign w_start = cfgb_ff[`CFGB_START_LSB+:AW];
  assign w_end = cfgb_ff[`CFGB_END_LSB+:AW];
  assign cfg_a = cfga_ff;
  assign cfg_b = cfgb_ff;
  // red idles closed and actuates on open, the rest the other way
  assign act = (typ == `TYPE_RED) ? ~closed : closed;
  assign inwin = in_window(angle, w_start, w_end);
  assign w_open = inwin & ~inwin_ff;
  assign w_close = ~inwin & inwin_ff;

  // config storage
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cfga_ff <= `CFGA_RESET;
      cfgb_ff <= `CFGB_RESET;
    end
    else
    begin
      if (wr_a)
        cfga_ff <= wdata;
      if (wr_b)
        cfgb_ff <= wdata;
    end
  end

  // evaluation; window state is tracked even while halted so arming is clean
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      act_ff <= 1'b0;
      inwin_ff <= 1'b0;
      seen_ff <= 1'b0;
      off_ff <= 1'b1;
      cnt_ff <= 8'h00;
      fault <= 1'b0;
    end
    else
    begin
      act_ff <= act;
      inwin_ff <= inwin;
      fault <= 1'b0;
      case (typ)
        `TYPE_RED, `TYPE_YELLOW:
        begin
          fault <= run & act;
        end
        `TYPE_GREEN:
        begin
          if (act & inwin)
            seen_ff <= 1'b1;
          if (w_open)
          begin
            fault <= run & act;
            seen_ff <= act & inwin;
          end
          if (w_close)
            fault <= run & ~seen_ff;
        end
        `TYPE_QUICK:
        begin
          // seen marks a full on-off pulse inside the window
          if (~act & act_ff & inwin_ff)
            seen_ff <= 1'b1;
          if (w_open)
            seen_ff <= 1'b0;
          fault <= run & ((act & ~inwin) | (w_close & ~seen_ff));
        end
        `TYPE_CONST:
        begin
          if (~act & ~inwin)
            off_ff <= 1'b1;
          if (act & inwin)
            seen_ff <= 1'b1;
          if (w_open)
          begin
            off_ff <= 1'b0;
            seen_ff <= act;
          end
          // drop inside window is immediate; rise-less window judged at end
          fault <= run & ((w_open & ~off_ff & act) | (inwin & ~act & act_ff & ~w_open)
                   | (w_close & ~seen_ff));
        end
        `TYPE_SPECIAL:
        begin
          if (act)
            cnt_ff <= 8'h00;
          else if (stroke)
          begin
            if (cnt_ff >= limit)
              fault <= run;
            else
              cnt_ff <= cnt_ff + 8'h01;
          end
        end
        default:
        begin
          seen_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== verif/die_guard_checker_assertions.sv
// port assertions for the die sensor window checker
`timescale 1ns/1ns
module die_guard_checker #(
  parameter NS = 4,
  parameter AW = 10
) (
  input wire core_clk,
  input wire rstn,
  input wire [NS-1:0] sensor_closed,
  input wire [AW-1:0] crank_angle,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire stop_top,
  input wire stop_emerg,
  input wire stroke_mark,
  input wire irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // reads of unmapped or write-only places, and a full interrupt mask
  sequence dead_read;
    rd && (addr == 8'hFC || addr == 8'h08);
  endsequence
  sequence mask_all;
    wr && addr == 8'h0C && wdata == 32'h0;
  endsequence
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not idle");
  chk_dead_read: assert property (dead_read |=> rdata == 32'h0)
    else $error("dead read not zero");
  chk_mark_wrap: assert property (crank_angle < $past(crank_angle) |-> ##[1:3] stroke_mark)
    else $error("no stroke mark");
  chk_mark_single: assert property (stroke_mark |=> !stroke_mark [*8])
    else $error("repeated stroke mark");
  chk_irq_cause: assert property (irq |-> stop_top || stop_emerg)
    else $error("irq without stop");
  chk_emerg_hold: assert property (stop_emerg && !(wr && addr == 8'h08) |=> stop_emerg)
    else $error("emergency stop dropped");
  chk_stop_hold: assert property ((stop_top || stop_emerg) && !(wr && addr == 8'h08)
    |=> (stop_top || stop_emerg))
    else $error("stop command dropped without clear");
  chk_irq_mask: assert property (mask_all |-> ##2 !irq)
    else $error("masked irq high");
  chk_reset_quiet: assert property ($rose(rstn) |-> !stop_top && !stop_emerg && !irq)
    else $error("outputs busy after reset");
endmodule
bind die_sensor_window_checker die_guard_checker #(.NS(NS), .AW(AW)) chk_u (.core_clk, .rstn,
  .sensor_closed, .crank_angle, .addr, .wdata, .wr, .rd, .rdata, .stop_top, .stop_emerg,
  .stroke_mark, .irq);

// ===== verif/die_sensor_window_checker_bench.sv
// self-checking bench for the die sensor window checker
`timescale 1ns/1ns
module die_sensor_window_checker_bench;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] pin_set = 4'h1;
  wire [3:0] sensor_closed;
  wire [9:0] crank_angle;
  wire [31:0] rdata;
  wire stop_top, stop_emerg, stroke_mark, irq;
  integer fails = 0;
  integer check_count = 0;
  integer i;
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  press_model pm_u (.core_clk, .pin_set, .sensor_closed, .crank_angle);
  die_sensor_window_checker dut_u (.core_clk, .rstn, .sensor_closed, .crank_angle, .addr,
    .wdata, .wr, .rd, .rdata, .stop_top, .stop_emerg, .stroke_mark, .irq);
  // word and flag comparisons
  task cmp(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task cmp_bit(input got, input exp);
  begin
    cmp({31'h0, got}, {31'h0, exp});
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // register bus cycles; read data taken from the cycle after the strobe
  task wr_reg(input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
  begin
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    cmp(rdata, e);
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge core_clk);
  end
  endtask
  // always steps at least one edge, so equal targets in a row mean a full stroke
  task wait_ang(input [9:0] v);
  begin
    i = 0;
    do
    begin
      @(posedge core_clk);
      i = i + 1;
    end
    while (crank_angle !== v && i < 300);
    if (crank_angle !== v)
    begin
      cmp(32'h0, 32'h1);
      close_out;
    end
  end
  endtask
  initial
  begin
    settle(10);
    rstn <= 1'b1;
    rd_chk(8'h20, 32'h7);
    rd_chk(8'h10, 32'hB4);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'hFC, 32'h0);
    wr_reg(8'h20, 32'h10);
    wr_reg(8'h28, 32'h01);
    wr_reg(8'h0C, 32'hF);
    wr_reg(8'h00, 32'h1);
    settle(8);
    cmp_bit(stop_top | stop_emerg, 1'b0);
    pin_set <= 4'h0;
    settle(8);
    cmp_bit(stop_emerg, 1'b1);
    cmp_bit(irq, 1'b1);
    rd_chk(8'h04, 32'h1);
    pin_set <= 4'h3;
    settle(8);
    wr_reg(8'h08, 32'h1);
    settle(8);
    cmp_bit(stop_top, 1'b1);
    cmp_bit(stop_emerg, 1'b0);
    rd_chk(8'h04, 32'h2);
    wr_reg(8'h0C, 32'h0);
    settle(2);
    cmp_bit(irq, 1'b0);
    pin_set <= 4'h1;
    settle(8);
    wr_reg(8'h08, 32'h2);
    wr_reg(8'h0C, 32'hF);
    // green, window 200..400: never actuated stops, actuated inside the window passes
    wr_reg(8'h34, 32'h019000C8);
    wr_reg(8'h30, 32'h02);
    wait_ang(10'd0);
    wait_ang(10'd420);
    rd_chk(8'h04, 32'h4);
    cmp_bit(stop_top, 1'b1);
    wait_ang(10'd0);
    cmp_bit(stroke_mark, 1'b0);
    settle(1);
    cmp_bit(stroke_mark, 1'b1);
    wr_reg(8'h08, 32'h4);
    wait_ang(10'd240);
    pin_set <= 4'h5;
    wait_ang(10'd320);
    pin_set <= 4'h1;
    wait_ang(10'd500);
    rd_chk(8'h04, 32'h0);
    // quick check: short pulse inside the window passes, on-time outside it stops
    wr_reg(8'h30, 32'h03);
    wait_ang(10'd240);
    pin_set <= 4'h5;
    settle(4);
    pin_set <= 4'h1;
    wait_ang(10'd500);
    rd_chk(8'h04, 32'h0);
    wait_ang(10'd600);
    pin_set <= 4'h5;
    settle(8);
    rd_chk(8'h04, 32'h4);
    pin_set <= 4'h1;
    settle(4);
    wr_reg(8'h08, 32'h4);
    // constant: on across the whole window passes, a drop inside it stops at once
    wr_reg(8'h30, 32'h04);
    wait_ang(10'd100);
    pin_set <= 4'h5;
    wait_ang(10'd460);
    pin_set <= 4'h1;
    settle(4);
    rd_chk(8'h04, 32'h0);
    wait_ang(10'd100);
    pin_set <= 4'h5;
    wait_ang(10'd300);
    pin_set <= 4'h1;
    settle(8);
    rd_chk(8'h04, 32'h4);
    wr_reg(8'h30, 32'h07);
    wr_reg(8'h08, 32'h4);
    // live view: only synced pin 0 high, angle one cycle behind the crank
    wait_ang(10'd40);
    rd_chk(8'h14, 32'h002C_0001);
    // smart stop: past the critical angle a top stop, before it an emergency stop
    wr_reg(8'h20, 32'h20);
    wait_ang(10'd600);
    pin_set <= 4'h0;
    settle(8);
    cmp_bit(stop_top, 1'b1);
    cmp_bit(stop_emerg, 1'b0);
    pin_set <= 4'h1;
    settle(4);
    wr_reg(8'h08, 32'h1);
    wait_ang(10'd40);
    pin_set <= 4'h0;
    settle(8);
    cmp_bit(stop_emerg, 1'b1);
    pin_set <= 4'h1;
    settle(4);
    wr_reg(8'h08, 32'h1);
    // special, emergency, at most two strokes without actuation
    wr_reg(8'h38, 32'h0215);
    wait_ang(10'd100);
    pin_set <= 4'h9;
    settle(4);
    pin_set <= 4'h1;
    wait_ang(10'd100);
    wait_ang(10'd100);
    cmp_bit(stop_emerg, 1'b0);
    wait_ang(10'd40);
    cmp_bit(stop_emerg, 1'b1);
    close_out;
  end
endmodule

// ===== verif/press_model.sv
// crank angle source and die sensor contacts
`timescale 1ns/1ns
module press_model (
  input wire core_clk,
  input wire [3:0] pin_set,
  output reg [3:0] sensor_closed,
  output reg [9:0] crank_angle
);
  initial crank_angle = 10'h000;
  initial sensor_closed = 4'h1;
  // four steps a cycle, so one stroke is 256 cycles; free running like a real crank
  always @(posedge core_clk)
  begin
    crank_angle <= crank_angle + 10'h004;
    sensor_closed <= pin_set;
  end
endmodule
